// [src/gpcfg_top.sv]
// Pad configuration registers for one 8-pin general-purpose port
//
// Our own choice: the plain strobed port.

module gpcfg_top
  import gpcfg_pkg::*;
#(
  parameter int NPINS = GPCFG_NPINS
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output gpcfg_pad_t o_pad
);
  logic [7:0] weak_r;
  logic [7:0] med_r;
  logic [7:0] strong_r;
  logic [7:0] od_r;
  logic [7:0] pu_r;
  logic [7:0] pd_r;
  logic [7:0] dir_r;
  logic [7:0] din_r;
  logic [7:0] wbits;
  gpcfg_pad_t pad_nxt;
  gpcfg_pad_t pad_rst;
  gpcfg_pad_t pad_q;
  logic [31:0] rdata_nxt;

  // Only the low field is taken; upper bits are dropped
  assign wbits = i_wdata[GPCFG_FIELD_LSB +: GPCFG_FIELD_W];

  // Drive strength selects, kept mutually exclusive per pin
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      weak_r <= GPCFG_WEAK_RST;
      med_r <= GPCFG_MED_RST;
      strong_r <= GPCFG_STRONG_RST;
    end else if (i_wr) begin
      unique case (i_addr)
        GPCFG_WEAK_OFF: begin
          weak_r <= wbits;
          med_r <= med_r & ~wbits;
          strong_r <= strong_r & ~wbits;
        end
        GPCFG_MED_OFF: begin
          med_r <= wbits;
          weak_r <= weak_r & ~wbits;
          strong_r <= strong_r & ~wbits;
        end
        GPCFG_STRONG_OFF: begin
          strong_r <= wbits;
          weak_r <= weak_r & ~wbits;
          med_r <= med_r & ~wbits;
        end
        default: begin
        end
      endcase
    end
  end

  // Open-drain select
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      od_r <= GPCFG_OD_RST;
    end else if (i_wr && i_addr == GPCFG_OD_OFF) begin
      od_r <= wbits;
    end
  end

  // Pull-up and pull-down, never both active
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      pu_r <= GPCFG_PU_RST;
      pd_r <= GPCFG_PD_RST;
    end else if (i_wr && i_addr == GPCFG_PU_OFF) begin
      pu_r <= wbits;
      pd_r <= pd_r & ~wbits;
    end else if (i_wr && i_addr == GPCFG_PD_OFF) begin
      pd_r <= wbits;
      pu_r <= pu_r & ~wbits;
    end
  end

  // Direction and digital input enable
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      dir_r <= GPCFG_DIR_RST;
      din_r <= GPCFG_DIN_RST;
    end else if (i_wr && i_addr == GPCFG_DIR_OFF) begin
      dir_r <= wbits;
    end else if (i_wr && i_addr == GPCFG_DIN_OFF) begin
      din_r <= wbits;
    end
  end

  // Pad settings assembled from the registers
  always_comb begin
    pad_nxt.weak_drive_bits = weak_r;
    pad_nxt.medium_drive_bits = med_r;
    pad_nxt.strong_drive_bits = strong_r;
    pad_nxt.open_drain_bits = od_r;
    pad_nxt.pull_up_bits = pu_r;
    pad_nxt.pull_down_bits = pd_r;
    pad_nxt.od_input_bits = od_r & ~dir_r;
    pad_nxt.od_output_bits = od_r & dir_r;
  end

  always_comb begin
    pad_rst.weak_drive_bits = GPCFG_WEAK_RST;
    pad_rst.medium_drive_bits = GPCFG_MED_RST;
    pad_rst.strong_drive_bits = GPCFG_STRONG_RST;
    pad_rst.open_drain_bits = GPCFG_OD_RST;
    pad_rst.pull_up_bits = GPCFG_PU_RST;
    pad_rst.pull_down_bits = GPCFG_PD_RST;
    pad_rst.od_input_bits = GPCFG_OD_RST;
    pad_rst.od_output_bits = GPCFG_OD_RST;
  end

  // Register stage plus one pipeline stage gives the second-clock update
  gpcfg_delay #(
    .STAGES(GPCFG_APPLY_STAGES - 1)
  ) u_delay (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_rst_val(pad_rst),
    .i_d(pad_nxt),
    .o_q(pad_q)
  );

  assign o_pad = pad_q;

  // Read mux, reserved bits zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (i_addr)
      GPCFG_DIR_OFF: rdata_nxt[7:0] = dir_r;
      GPCFG_WEAK_OFF: rdata_nxt[7:0] = weak_r;
      GPCFG_MED_OFF: rdata_nxt[7:0] = med_r;
      GPCFG_STRONG_OFF: rdata_nxt[7:0] = strong_r;
      GPCFG_OD_OFF: rdata_nxt[7:0] = od_r;
      GPCFG_PU_OFF: rdata_nxt[7:0] = pu_r;
      GPCFG_PD_OFF: rdata_nxt[7:0] = pd_r;
      GPCFG_DIN_OFF: rdata_nxt[7:0] = din_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= rdata_nxt;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule // gpcfg_top

// [common/gpcfg_pkg.sv]
// Package of register map, reset values and pad carrier types for the pad configuration block
package gpcfg_pkg;
  localparam int GPCFG_NPINS = 8;
  localparam int GPCFG_AW = 12;
  localparam logic [11:0] GPCFG_DIR_OFF = 12'h400;
  localparam logic [11:0] GPCFG_WEAK_OFF = 12'h500;
  localparam logic [11:0] GPCFG_MED_OFF = 12'h504;
  localparam logic [11:0] GPCFG_STRONG_OFF = 12'h508;
  localparam logic [11:0] GPCFG_OD_OFF = 12'h50c;
  localparam logic [11:0] GPCFG_PU_OFF = 12'h510;
  localparam logic [11:0] GPCFG_PD_OFF = 12'h514;
  localparam logic [11:0] GPCFG_DIN_OFF = 12'h51c;
  localparam logic [7:0] GPCFG_DIR_RST = 8'h00;
  localparam logic [7:0] GPCFG_WEAK_RST = 8'hff;
  localparam logic [7:0] GPCFG_MED_RST = 8'h00;
  localparam logic [7:0] GPCFG_STRONG_RST = 8'h00;
  localparam logic [7:0] GPCFG_OD_RST = 8'h00;
  localparam logic [7:0] GPCFG_PU_RST = 8'hff;
  localparam logic [7:0] GPCFG_PD_RST = 8'h00;
  localparam logic [7:0] GPCFG_DIN_RST = 8'hff;
  localparam int GPCFG_FIELD_LSB = 0;
  localparam int GPCFG_FIELD_W = 8;
  localparam int GPCFG_APPLY_STAGES = 2;

  typedef struct packed {
    logic [7:0] weak_drive_bits;
    logic [7:0] medium_drive_bits;
    logic [7:0] strong_drive_bits;
    logic [7:0] open_drain_bits;
    logic [7:0] pull_up_bits;
    logic [7:0] pull_down_bits;
    logic [7:0] od_input_bits;
    logic [7:0] od_output_bits;
  } gpcfg_pad_t;
endpackage

// [src/gpcfg_delay.sv]
// Pipeline that holds pad settings back by a fixed number of clocks
module gpcfg_delay
  import gpcfg_pkg::*;
#(
  parameter int STAGES = GPCFG_APPLY_STAGES
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire gpcfg_pad_t i_rst_val,
  input wire gpcfg_pad_t i_d,
  output gpcfg_pad_t o_q
);
  gpcfg_pad_t stage_r [STAGES];

  genvar g;
  generate
    for (g = 0; g < STAGES; g++) begin : g_stage
      always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
          stage_r[g] <= i_rst_val;
        end else if (g == 0) begin
          stage_r[g] <= i_d;
        end else begin
          stage_r[g] <= stage_r[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  assign o_q = stage_r[STAGES-1];
endmodule // gpcfg_delay

// [dv/gpcfg_pad_model.sv]
// Pad model resolving pin levels from pull settings
module gpcfg_pad_model
  import gpcfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire gpcfg_pad_t i_pad,
  output logic [7:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tgl_r = 1'b0;
  always_ff @(posedge i_ref_clk) tgl_r <= ~tgl_r;
  // Unpulled pins float with a changing pattern
  assign o_pin = i_pad.pull_up_bits | (~i_pad.pull_down_bits & {8{tgl_r}});
endmodule // gpcfg_pad_model

// [dv/gpcfg_chk.sv]
// Assertion checker for the pad configuration block
module gpcfg_chk
  import gpcfg_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire gpcfg_pad_t o_pad
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  logic [7:0] w1_r;
  logic [7:0] w2_r;
  always_ff @(posedge i_ref_clk) begin
    w1_r <= i_wdata[7:0];
    w2_r <= w1_r;
  end
  sequence wr_s(logic [11:0] a);
    i_wr && i_addr == a;
  endsequence
  strong_val_a: assert property (wr_s(GPCFG_STRONG_OFF) |-> ##2
    o_pad.strong_drive_bits == w2_r) else $error("strong value");
  strong_clr_a: assert property (wr_s(GPCFG_STRONG_OFF) |-> ##2
    ((o_pad.weak_drive_bits | o_pad.medium_drive_bits) & w2_r) == 8'h00) else $error("strong clr");
  med_clr_a: assert property (wr_s(GPCFG_MED_OFF) |-> ##2
    ((o_pad.weak_drive_bits | o_pad.strong_drive_bits) & w2_r) == 8'h00) else $error("med clr");
  od_val_a: assert property (wr_s(GPCFG_OD_OFF) |-> ##2
    o_pad.open_drain_bits == w2_r) else $error("od value");
  od_dir_a: assert property ((o_pad.od_input_bits & o_pad.od_output_bits) == 8'h00 &&
    (o_pad.od_input_bits | o_pad.od_output_bits) == o_pad.open_drain_bits) else $error("od dir");
  pu_val_a: assert property (wr_s(GPCFG_PU_OFF) |-> ##2
    o_pad.pull_up_bits == w2_r) else $error("pu value");
  pu_clr_a: assert property (wr_s(GPCFG_PU_OFF) |-> ##2
    (o_pad.pull_down_bits & w2_r) == 8'h00) else $error("pu clr");
  pd_clr_a: assert property (wr_s(GPCFG_PD_OFF) |-> ##2
    (o_pad.pull_up_bits & w2_r) == 8'h00) else $error("pd clr");
  pad_hold_a: assert property (!i_wr ##1 !i_wr |=> $stable(o_pad))
    else $error("pad moved");
endmodule // gpcfg_chk
bind gpcfg_top gpcfg_chk chk_u (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .o_pad);

// [dv/tb_top.sv]
// Self-checking bench for the pad configuration block
module tb_top;
  import gpcfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
  logic i_ref_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0;
  logic [31:0] o_rdata;
  gpcfg_pad_t o_pad;
  logic [7:0] pin;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  gpcfg_top dut_u (.i_ref_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_pad);
  gpcfg_pad_model pad_u (.i_ref_clk, .i_pad(o_pad), .o_pin(pin));
  initial forever #20 i_ref_clk = ~i_ref_clk;
  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 `CHK("rdata", e, o_rdata)
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_srst <= 1'b0;
    rd(GPCFG_STRONG_OFF, 32'h0);
    rd(GPCFG_OD_OFF, 32'h0);
    rd(GPCFG_PU_OFF, 32'hff);
    wr(GPCFG_MED_OFF, 32'hff);
    wr(GPCFG_STRONG_OFF, 32'h0f);
    #1 `CHK("pad early", 8'hff, o_pad.medium_drive_bits)
    @(posedge i_ref_clk);
    #1 `CHK("pad late", 8'hf0, o_pad.medium_drive_bits)
    rd(GPCFG_WEAK_OFF, 32'h0);
    rd(GPCFG_MED_OFF, 32'hf0);
    rd(GPCFG_STRONG_OFF, 32'h0f);
    wr(GPCFG_WEAK_OFF, 32'hff);
    wr(GPCFG_STRONG_OFF, 32'h03);
    rd(GPCFG_WEAK_OFF, 32'hfc);
    wr(GPCFG_MED_OFF, 32'h01);
    rd(GPCFG_STRONG_OFF, 32'h02);
    wr(GPCFG_DIR_OFF, 32'h0f);
    wr(GPCFG_DIN_OFF, 32'hff);
    wr(GPCFG_OD_OFF, 32'habcdef3c);
    rd(GPCFG_OD_OFF, 32'h3c);
    `CHK("od in", 8'h30, o_pad.od_input_bits)
    `CHK("od out", 8'h0c, o_pad.od_output_bits)
    wr(GPCFG_PD_OFF, 32'h0f);
    rd(GPCFG_PU_OFF, 32'hf0);
    wr(GPCFG_PU_OFF, 32'h03);
    rd(GPCFG_PU_OFF, 32'h03);
    rd(GPCFG_PD_OFF, 32'h0c);
    `CHK("pin", 8'h03, pin & 8'h0f)
    rd(12'h7fc, 32'h0);
    stop_test();
  end
endmodule // tb_top
